//--- common/nv_access_consts.vh
// Purpose: constants for the nonvolatile self-access controller
// Assumes: 20 MHz system clock
// Notes:   times in ns, cycle counts derived from them
`ifndef NV_ACCESS_CONSTS_VH
`define NV_ACCESS_CONSTS_VH

// ======================================================================
// register selects on the special function register port
`define NV_SEL_DATA_LOW        3'h0
`define NV_SEL_DATA_HIGH       3'h1
`define NV_SEL_ADDR_LOW        3'h2
`define NV_SEL_ADDR_HIGH       3'h3
`define NV_SEL_CONTROL         3'h4
`define NV_SEL_UNLOCK_PORT     3'h5

// ======================================================================
// control field positions
`define NV_CTL_READ_BIT        0
`define NV_CTL_WRITE_BIT       1
`define NV_CTL_PERMIT_BIT      2
`define NV_CTL_ERROR_BIT       3
`define NV_CTL_SPACE_BIT       7

// ======================================================================
// unlock keys and reset values
`define NV_UNLOCK_KEY1         8'h55
`define NV_UNLOCK_KEY2         8'hAA
`define NV_RESET_BYTE          8'h00

// ======================================================================
// timing
`define NV_CLK_PERIOD_NS       50
`define NV_ERASE_TIME_NS       2000000
`define NV_PROG_TIME_NS        2000000
`define NV_ERASE_CYCLES        ((`NV_ERASE_TIME_NS + `NV_CLK_PERIOD_NS - 1) / `NV_CLK_PERIOD_NS)
`define NV_PROG_CYCLES         ((`NV_PROG_TIME_NS + `NV_CLK_PERIOD_NS - 1) / `NV_CLK_PERIOD_NS)
`define NV_PROG_READ_DELAY     2'h2

`endif

//--- hdl/nv_opcode_filter.v
// Purpose: turns a fetched word that is no valid instruction into a no-op
// Assumes: 14-bit instruction words
// Notes:   invalid patterns are given by fixed compares on the word bits
`timescale 1ns/100ps
module nv_opcode_filter #(
   parameter [13:0] NOP_WORD = 14'h0000
) (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        ce_i,
   input  wire        valid_i,
   input  wire [13:0] word_i,
   output reg         valid_o,
   output reg  [13:0] word_o
);

   reg legal;

   // opcodes with an unused bit pattern in the byte-oriented group decode as invalid
   always @* begin
      legal = 1'b1;
      if (word_i[13:12] == 2'b00 && word_i[11:8] == 4'h0 && word_i[7] == 1'b0 &&
          word_i[6:0] != 7'h00 && word_i[6:0] != 7'h08 && word_i[6:0] != 7'h09 &&
          word_i[6:0] != 7'h62 && word_i[6:0] != 7'h63 && word_i[6:0] != 7'h64 &&
          word_i[4:0] != 5'h00)
         legal = 1'b0;
      if (word_i[13:12] == 2'b00 && word_i[11:8] == 4'h1 && word_i[7] == 1'b0 && word_i[6:0] != 7'h00)
         legal = 1'b0;
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         valid_o <= 1'b0;
         word_o  <= NOP_WORD;
      end else if (ce_i) begin
         valid_o <= valid_i;
         word_o  <= legal ? word_i : NOP_WORD; // see (RULE5)
      end
   end

endmodule // nv_opcode_filter

//--- hdl/nv_self_access.v
// Purpose: self-access controller for data EEPROM and flash program memory
// Assumes: core writes the six special function registers over a select port
// Notes:   arrays sit outside; this block drives their strobes
// Operation
// (RULE1) each access touches one byte or word
// (RULE2) writes erase first, then program
// (RULE3) no bulk erase reachable from user code
// (RULE4) program memory stores any 14-bit value
// (RULE5) invalid fetched words execute as no-op
// (RULE6) internal timer sets write duration
// (RULE7) data EEPROM write runs in background
// (RULE8) program write stalls core, blocks memory
// (RULE9) clocks run, interrupts held during program write
// (RULE10) finish pipeline instruction, then take vector
// (RULE11) access only through six indirect registers
// (RULE12) address low selects byte, data low holds
// (RULE13) no address wrap in small data memory
// (RULE14) large data memory decodes all eight bits
// (RULE15) address pair 13-bit, data pair 14-bit
// (RULE16) program addresses beyond range never wrap
// (RULE17) program reads do not stall the core
// (RULE18) space select routes to data or program
// (RULE19) read strobe self-clears, fixed data latency
// (RULE20) write end clears strobe, sets done flag
// (RULE21) permit plus 55h, AAh unlock before write
// (RULE22) new starts ignored while write busy
`timescale 1ns/100ps
`include "nv_access_consts.vh"
module nv_self_access #(
   parameter DATA_DEPTH  = 256,
   parameter PROG_AW     = 13,
   parameter PROG_DEPTH  = 8192,
   parameter ERASE_CYCLES = `NV_ERASE_CYCLES,
   parameter PROG_CYCLES  = `NV_PROG_CYCLES
) (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        ce_i,
   input  wire        sfr_wr_i,
   input  wire [2:0]  sfr_sel_i,
   input  wire [7:0]  sfr_wdata_i,
   input  wire        done_flag_clr_i,
   input  wire        irq_event_i,
   input  wire        irq_enable_i,
   input  wire        fetch_valid_i,
   input  wire [13:0] fetch_word_i,
   input  wire [7:0]  ee_rdata_i,
   input  wire [13:0] pm_rdata_i,
   output reg  [7:0]  data_low_o,
   output reg  [5:0]  data_high_o,
   output reg  [7:0]  addr_low_o,
   output reg  [7:0]  addr_high_o,
   output reg  [7:0]  control_o,
   output reg         write_done_flag_o,
   output reg         core_stall_o,
   output reg         irq_vector_o,
   output reg         exec_valid_o,
   output reg  [13:0] exec_word_o,
   output reg         ee_rd_o,
   output reg         ee_erase_o,
   output reg         ee_prog_o,
   output reg  [7:0]  ee_addr_o,
   output reg  [7:0]  ee_wdata_o,
   output reg         pm_rd_o,
   output reg         pm_erase_o,
   output reg         pm_prog_o,
   output reg  [PROG_AW-1:0] pm_addr_o,
   output reg  [13:0] pm_wdata_o
);

   // ======================================================================
   // states
   localparam [4:0] ST_IDLE  = 5'b0_0001;
   localparam [4:0] ST_ERASE = 5'b0_0010;
   localparam [4:0] ST_PROG  = 5'b0_0100;
   localparam [4:0] ST_PRD   = 5'b0_1000;
   localparam [4:0] ST_DRAIN = 5'b1_0000;

   reg  [4:0]  state;
   reg  [1:0]  unlock;
   reg         space_prog;
   reg         op_prog;
   reg  [1:0]  prd_cnt;
   reg         irq_pending;
   reg         t_start;
   reg  [23:0] t_cycles;
   reg         addr_ok;
   reg         idle_ok;
   reg         start_wr;
   reg         start_rd;
   wire        t_busy;
   wire        t_done;
   wire        f_valid;
   wire [13:0] f_word;
   wire [15:0] prog_addr;

   assign prog_addr = {addr_high_o, addr_low_o}; // see (RULE15)

   // out-of-range addresses are refused rather than folded back to zero
   // so 80h in the small data configuration never lands on 00h
   always @* begin
      if (control_o[`NV_CTL_SPACE_BIT])
         addr_ok = (prog_addr < PROG_DEPTH); // see (RULE16)
      else
         addr_ok = ({8'h00, addr_low_o} < DATA_DEPTH); // see (RULE13) (RULE14)
   end

   // ======================================================================
   // start qualification
   // a start is only taken with the sequencer and the timer both at rest, so a
   // second strobe can never cut an erase or program phase short
   always @* begin
      idle_ok  = (state == ST_IDLE) && !t_busy; // see (RULE22)
      start_wr = sfr_wdata_i[`NV_CTL_WRITE_BIT] && sfr_wdata_i[`NV_CTL_PERMIT_BIT] &&
                 control_o[`NV_CTL_PERMIT_BIT] && (unlock == 2'b10) && addr_ok; // see (RULE21)
      // a write refused for permit or unlock that also carries the read bit still reads; an out-of-range address refuses both
      start_rd = sfr_wdata_i[`NV_CTL_READ_BIT] && addr_ok;
   end

   // ======================================================================
   // self timer
   // each phase lasts the loaded count plus two cycles of start and done handshake
   nv_self_timer #(
      .WIDTH    (24)
   ) u_timer (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n_i),
      .ce_i     (ce_i),
      .start_i  (t_start),
      .cycles_i (t_cycles),
      .busy_o   (t_busy),
      .done_o   (t_done)
   );

   // ======================================================================
   // fetch path
   // words come out two cycles after the fetch, invalid ones as the no-op
   nv_opcode_filter #(
      .NOP_WORD (14'h0000)
   ) u_filter (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n_i),
      .ce_i     (ce_i),
      .valid_i  (fetch_valid_i),
      .word_i   (fetch_word_i),
      .valid_o  (f_valid),
      .word_o   (f_word)
   );

   // ======================================================================
   // register file and sequencer
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state             <= ST_IDLE;
         unlock            <= 2'b00;
         space_prog        <= 1'b0;
         op_prog           <= 1'b0;
         prd_cnt           <= 2'b00;
         irq_pending       <= 1'b0;
         t_start           <= 1'b0;
         t_cycles          <= 24'h00_0000;
         data_low_o        <= `NV_RESET_BYTE;
         data_high_o       <= 6'h00;
         addr_low_o        <= `NV_RESET_BYTE;
         addr_high_o       <= `NV_RESET_BYTE;
         control_o         <= `NV_RESET_BYTE;
         write_done_flag_o <= 1'b0;
         core_stall_o      <= 1'b0;
         irq_vector_o      <= 1'b0;
         exec_valid_o      <= 1'b0;
         exec_word_o       <= 14'h0000;
         ee_rd_o           <= 1'b0;
         ee_erase_o        <= 1'b0;
         ee_prog_o         <= 1'b0;
         ee_addr_o         <= 8'h00;
         ee_wdata_o        <= 8'h00;
         pm_rd_o           <= 1'b0;
         pm_erase_o        <= 1'b0;
         pm_prog_o         <= 1'b0;
         pm_addr_o         <= {PROG_AW{1'b0}};
         pm_wdata_o        <= 14'h0000;
      end else if (ce_i) begin
         t_start      <= 1'b0;
         ee_rd_o      <= 1'b0;
         pm_rd_o      <= 1'b0;
         irq_vector_o <= 1'b0;
         // during a program write the fetch path is frozen
         exec_valid_o <= f_valid && !core_stall_o; // see (RULE8)
         exec_word_o  <= f_word;
         // done flag: a set in the same cycle as a clear wins
         if (done_flag_clr_i)
            write_done_flag_o <= 1'b0;
         if (irq_event_i && core_stall_o)
            irq_pending <= 1'b1; // see (RULE9)
         // register writes from the core
         if (sfr_wr_i) begin
            // any register write in between breaks the unlock sequence
            unlock <= 2'b00;
            case (sfr_sel_i)
               `NV_SEL_DATA_LOW:  data_low_o  <= sfr_wdata_i; // see (RULE11) (RULE12)
               `NV_SEL_DATA_HIGH: data_high_o <= sfr_wdata_i[5:0];
               `NV_SEL_ADDR_LOW:  addr_low_o  <= sfr_wdata_i;
               `NV_SEL_ADDR_HIGH: addr_high_o <= sfr_wdata_i;
               `NV_SEL_UNLOCK_PORT: begin
                  if (sfr_wdata_i == `NV_UNLOCK_KEY1 && control_o[`NV_CTL_PERMIT_BIT])
                     unlock <= 2'b01;
                  else if (sfr_wdata_i == `NV_UNLOCK_KEY2 && unlock == 2'b01)
                     unlock <= 2'b10;
               end
               `NV_SEL_CONTROL: begin
                  control_o[`NV_CTL_PERMIT_BIT] <= sfr_wdata_i[`NV_CTL_PERMIT_BIT];
                  control_o[`NV_CTL_ERROR_BIT]  <= sfr_wdata_i[`NV_CTL_ERROR_BIT];
                  if (idle_ok) begin // see (RULE22)
                     control_o[`NV_CTL_SPACE_BIT] <= sfr_wdata_i[`NV_CTL_SPACE_BIT]; // see (RULE18)
                     space_prog <= sfr_wdata_i[`NV_CTL_SPACE_BIT];
                     if (start_wr) begin // see (RULE21)
                        control_o[`NV_CTL_WRITE_BIT] <= 1'b1;
                        op_prog  <= space_prog;
                        t_start  <= 1'b1;
                        t_cycles <= ERASE_CYCLES[23:0]; // see (RULE6)
                        state    <= ST_ERASE; // see (RULE2)
                        if (space_prog) begin
                           pm_erase_o   <= 1'b1; // see (RULE1)
                           pm_addr_o    <= prog_addr[PROG_AW-1:0];
                           pm_wdata_o   <= {data_high_o, data_low_o}; // see (RULE4)
                           core_stall_o <= 1'b1; // see (RULE8)
                        end else begin
                           ee_erase_o <= 1'b1; // see (RULE7)
                           ee_addr_o  <= addr_low_o;
                           ee_wdata_o <= data_low_o;
                        end
                     end else if (start_rd) begin
                        control_o[`NV_CTL_READ_BIT] <= 1'b1; // see (RULE19)
                        if (space_prog) begin
                           pm_rd_o   <= 1'b1; // see (RULE17)
                           pm_addr_o <= prog_addr[PROG_AW-1:0];
                           prd_cnt   <= `NV_PROG_READ_DELAY;
                           state     <= ST_PRD;
                        end else begin
                           ee_rd_o   <= 1'b1;
                           ee_addr_o <= addr_low_o;
                        end
                     end
                  end
               end
               default: ;
            endcase
         end
         // data EEPROM read answers in the next cycle
         if (ee_rd_o) begin
            data_low_o <= ee_rdata_i;
            control_o[`NV_CTL_READ_BIT] <= 1'b0; // see (RULE19)
         end
         case (state)
            ST_IDLE: ;
            ST_PRD: begin
               // program read data is taken two cycles after its strobe
               if (prd_cnt == 2'b01) begin
                  data_low_o  <= pm_rdata_i[7:0]; // see (RULE15)
                  data_high_o <= pm_rdata_i[13:8];
                  control_o[`NV_CTL_READ_BIT] <= 1'b0;
                  state <= ST_IDLE;
               end
               prd_cnt <= prd_cnt - 2'b01;
            end
            ST_ERASE: begin
               // erase done: the same timer is reloaded for the program phase
               if (t_done) begin
                  ee_erase_o <= 1'b0;
                  pm_erase_o <= 1'b0;
                  ee_prog_o  <= !op_prog;
                  pm_prog_o  <= op_prog;
                  t_start    <= 1'b1;
                  t_cycles   <= PROG_CYCLES[23:0]; // see (RULE6)
                  state      <= ST_PROG;
               end
            end
            ST_PROG: begin
               // a program-memory write drains one cycle before any vector
               if (t_done) begin
                  ee_prog_o <= 1'b0;
                  pm_prog_o <= 1'b0;
                  control_o[`NV_CTL_WRITE_BIT] <= 1'b0; // see (RULE20)
                  write_done_flag_o <= 1'b1; // see (RULE20)
                  state <= op_prog ? ST_DRAIN : ST_IDLE;
                  core_stall_o <= 1'b0;
               end
            end
            ST_DRAIN: begin
               // pipeline instruction executes this cycle, vector follows
               irq_vector_o <= irq_enable_i && (irq_pending || irq_event_i); // see (RULE10)
               irq_pending  <= 1'b0;
               state        <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
   // no bulk-erase strobe exists on this block at all (see (RULE3))

endmodule // nv_self_access

//--- hdl/nv_self_timer.v
// Purpose: self timer that measures erase and program phases
// Assumes: start is a one-cycle pulse while idle
// Notes:   done pulses one cycle when the count runs out
`timescale 1ns/100ps
module nv_self_timer #(
   parameter WIDTH = 24
) (
   input  wire             clk_i,
   input  wire             rst_n_i,
   input  wire             ce_i,
   input  wire             start_i,
   input  wire [WIDTH-1:0] cycles_i,
   output reg              busy_o,
   output reg              done_o
);

   reg [WIDTH-1:0] count;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count  <= {WIDTH{1'b0}};
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         if (start_i && !busy_o) begin
            count  <= cycles_i;
            busy_o <= 1'b1;
         end else if (busy_o) begin
            if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end else begin
               count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule // nv_self_timer

//--- tb/nv_array_model.sv
// Purpose: behavioural data and program arrays
// Assumes: erase and program strobes are levels
// Notes:   programming only clears bits, so a skipped erase shows up
`timescale 1ns/100ps
module nv_array_model (
   input  wire        clk_i,
   input  wire        ee_erase_i,
   input  wire        ee_prog_i,
   input  wire [7:0]  ee_addr_i,
   input  wire [7:0]  ee_wdata_i,
   input  wire        pm_erase_i,
   input  wire        pm_prog_i,
   input  wire [12:0] pm_addr_i,
   input  wire [13:0] pm_wdata_i,
   output wire [7:0]  ee_rdata_o,
   output wire [13:0] pm_rdata_o
);
   reg [7:0]  ee_mem [0:255];
   reg [13:0] pm_mem [0:8191];
   integer    k;
   initial begin
      for (k = 0; k < 8192; k = k + 1) begin
         pm_mem[k] = 14'h0000;
         if (k < 256) ee_mem[k] = 8'h00;
      end
   end
   always @(posedge clk_i) begin
      if (ee_erase_i) ee_mem[ee_addr_i] <= 8'hFF;
      if (ee_prog_i) ee_mem[ee_addr_i] <= ee_mem[ee_addr_i] & ee_wdata_i;
      if (pm_erase_i) pm_mem[pm_addr_i] <= 14'h3FFF;
      if (pm_prog_i) pm_mem[pm_addr_i] <= pm_mem[pm_addr_i] & pm_wdata_i;
   end
   assign ee_rdata_o = ee_mem[ee_addr_i];
   assign pm_rdata_o = pm_mem[pm_addr_i];
endmodule // nv_array_model

//--- tb/nv_self_access_properties.sv
// Purpose: port assertions for the nonvolatile self-access controller
// Assumes: ce_i held high, ERASE_CYCLES and PROG_CYCLES handed on by the bind
// Notes:   phase lengths are measured with helper counters
`timescale 1ns/100ps
module nv_self_access_properties #(
   parameter ERASE_CYCLES = 8,
   parameter PROG_CYCLES  = 8
) (
   input wire        clk_i,
   input wire        rst_n_i,
   input wire        done_flag_clr_i,
   input wire        fetch_valid_i,
   input wire [7:0]  ee_rdata_i,
   input wire [7:0]  data_low_o,
   input wire [7:0]  addr_low_o,
   input wire [7:0]  control_o,
   input wire        write_done_flag_o,
   input wire        core_stall_o,
   input wire        exec_valid_o,
   input wire        ee_rd_o,
   input wire        ee_erase_o,
   input wire        ee_prog_o,
   input wire [7:0]  ee_addr_o,
   input wire        pm_rd_o,
   input wire        pm_erase_o,
   input wire        pm_prog_o
);
   // ======================================================================
   // helper counters
   reg  [15:0] er_cnt;
   reg  [15:0] pr_cnt;
   wire        erasing = ee_erase_o | pm_erase_o;
   wire        progging = ee_prog_o | pm_prog_o;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         er_cnt <= 16'h0000;
         pr_cnt <= 16'h0000;
      end else begin
         er_cnt <= erasing ? er_cnt + 16'h0001 : 16'h0000;
         pr_cnt <= progging ? pr_cnt + 16'h0001 : 16'h0000;
      end
   end
   // ======================================================================
   // properties
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_read_end;
      !control_o[0] && (data_low_o == $past(ee_rdata_i));
   endsequence
   sequence s_write_end;
      ##[0:2] (write_done_flag_o && !control_o[1]);
   endsequence
   ee_read_load_a: assert property (ee_rd_o |=> s_read_end) else $error("read data not loaded");
   ee_erase_first_a: assert property ($rose(ee_prog_o) |-> $past(ee_erase_o)) else $error("no erase");
   pm_erase_first_a: assert property ($rose(pm_prog_o) |-> $past(pm_erase_o)) else $error("no erase");
   one_unit_a: assert property (!((ee_erase_o | ee_prog_o) && (pm_erase_o | pm_prog_o))) else $error("two units");
   erase_time_a: assert property ($fell(erasing) |-> er_cnt == ERASE_CYCLES + 2) else $error("erase length");
   prog_time_a: assert property ($fell(progging) |-> pr_cnt == PROG_CYCLES + 2) else $error("program length");
   pm_write_stall_a: assert property (pm_erase_o | pm_prog_o |-> core_stall_o) else $error("core not stalled");
   ee_background_a: assert property (ee_erase_o | ee_prog_o |-> !core_stall_o) else $error("core stalled");
   write_done_a: assert property ($fell(progging) |-> s_write_end) else $error("write end wrong");
   flag_hold_a: assert property (write_done_flag_o && !done_flag_clr_i |=> write_done_flag_o) else $error("flag lost");
   fetch_pass_a: assert property (fetch_valid_i ##1 !core_stall_o |=> exec_valid_o) else $error("fetch lost");
   pm_read_free_a: assert property (pm_rd_o |-> !core_stall_o) else $error("read stalls core");
   ee_addr_use_a: assert property ($rose(ee_erase_o) |-> ee_addr_o == $past(addr_low_o)) else $error("wrong byte");
endmodule // nv_self_access_properties

bind nv_self_access nv_self_access_properties #(
   .ERASE_CYCLES(ERASE_CYCLES),
   .PROG_CYCLES (PROG_CYCLES)
) u_props (.clk_i, .rst_n_i, .done_flag_clr_i, .fetch_valid_i, .ee_rdata_i, .data_low_o, .addr_low_o,
   .control_o, .write_done_flag_o, .core_stall_o, .exec_valid_o, .ee_rd_o, .ee_erase_o, .ee_prog_o,
   .ee_addr_o, .pm_rd_o, .pm_erase_o, .pm_prog_o);

//--- tb/nv_self_access_tb.sv
// Purpose: self-checking bench for nv_self_access
// Assumes: short erase and program counts of 8 cycles
// Notes:   inputs change on the falling edge
`timescale 1ns/100ps
module nv_self_access_tb;
   reg         clk_i, rst_n_i, sfr_wr_i, done_flag_clr_i, irq_event_i, irq_enable_i, fetch_valid_i;
   reg  [2:0]  sfr_sel_i;
   reg  [7:0]  sfr_wdata_i;
   reg  [13:0] fetch_word_i;
   wire [7:0]  ee_rdata_i, data_low_o, addr_low_o, addr_high_o, control_o, ee_addr_o, ee_wdata_o;
   wire [13:0] pm_rdata_i, exec_word_o, pm_wdata_o;
   wire [5:0]  data_high_o;
   wire [12:0] pm_addr_o;
   wire        write_done_flag_o, core_stall_o, irq_vector_o, exec_valid_o, ee_rd_o, ee_erase_o;
   wire        ee_prog_o, pm_rd_o, pm_erase_o, pm_prog_o;
   integer     bad_count, compares, n;
   integer     vec_cnt = 0;

   nv_self_access #(.ERASE_CYCLES(8), .PROG_CYCLES(8)) i_nv_self_access (.clk_i, .rst_n_i, .ce_i(1'b1),
      .sfr_wr_i, .sfr_sel_i, .sfr_wdata_i, .done_flag_clr_i, .irq_event_i, .irq_enable_i, .fetch_valid_i,
      .fetch_word_i, .ee_rdata_i, .pm_rdata_i, .data_low_o, .data_high_o, .addr_low_o, .addr_high_o,
      .control_o, .write_done_flag_o, .core_stall_o, .irq_vector_o, .exec_valid_o, .exec_word_o, .ee_rd_o,
      .ee_erase_o, .ee_prog_o, .ee_addr_o, .ee_wdata_o, .pm_rd_o, .pm_erase_o, .pm_prog_o, .pm_addr_o,
      .pm_wdata_o);
   nv_array_model i_nv_array_model (.clk_i, .ee_erase_i(ee_erase_o), .ee_prog_i(ee_prog_o),
      .ee_addr_i(ee_addr_o), .ee_wdata_i(ee_wdata_o), .pm_erase_i(pm_erase_o), .pm_prog_i(pm_prog_o),
      .pm_addr_i(pm_addr_o), .pm_wdata_i(pm_wdata_o), .ee_rdata_o(ee_rdata_i), .pm_rdata_o(pm_rdata_i));

   // ======================================================================
   // tasks
   task finish_test;
      begin
         $display("compares=%0d bad_count=%0d", compares, bad_count);
         if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task sfr(input [2:0] s, input [7:0] v);
      begin
         @(negedge clk_i);
         sfr_sel_i = s;
         sfr_wdata_i = v;
         sfr_wr_i = 1'b1;
         @(negedge clk_i);
         sfr_wr_i = 1'b0;
      end
   endtask
   task setup(input [7:0] ah, input [7:0] al, input [7:0] dh, input [7:0] dl);
      begin
         sfr(3'h3, ah);
         sfr(3'h2, al);
         sfr(3'h1, dh);
         sfr(3'h0, dl);
      end
   endtask
   // permit, two keys, then the write strobe
   task wr_start(input [7:0] sp, input [7:0] key2);
      begin
         sfr(3'h4, sp | 8'h04);
         sfr(3'h5, 8'h55);
         sfr(3'h5, key2);
         sfr(3'h4, sp | 8'h06);
      end
   endtask
   task wait_flag(input exp);
      begin
         n = 0;
         while (n < 60 && write_done_flag_o !== 1'b1) begin
            @(negedge clk_i);
            n = n + 1;
         end
         if (exp && n == 60) begin
            bad_count = bad_count + 1;
            finish_test;
         end
         chk(write_done_flag_o, exp);
         done_flag_clr_i = 1'b1;
         @(negedge clk_i);
         done_flag_clr_i = 1'b0;
         chk({control_o[1], write_done_flag_o}, 0);
      end
   endtask
   task rd(input [7:0] sp, input [7:0] ah, input [7:0] al, input [15:0] exp);
      begin
         sfr(3'h3, ah);
         sfr(3'h2, al);
         sfr(3'h4, sp | 8'h01);
         n = 0;
         while (n < 10 && control_o[0] !== 1'b0) begin
            @(negedge clk_i);
            n = n + 1;
         end
         if (n == 10) begin
            bad_count = bad_count + 1;
            finish_test;
         end
         repeat (2) @(negedge clk_i);
         chk({2'b00, data_high_o & {6{sp[7]}}, data_low_o}, exp);
      end
   endtask

   always @(posedge clk_i) if (irq_vector_o === 1'b1) vec_cnt <= vec_cnt + 1;

   // ======================================================================
   // stimulus
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   initial begin
      {rst_n_i, sfr_wr_i, done_flag_clr_i, irq_event_i, irq_enable_i, fetch_valid_i} = 6'h00;
      {sfr_sel_i, sfr_wdata_i, fetch_word_i} = 25'h000_0000;
      {bad_count, compares} = 0;
      repeat (10) @(negedge clk_i);
      rst_n_i = 1'b1;
      chk({control_o, 7'h00, write_done_flag_o}, 16'h0000);
      setup(8'h00, 8'h00, 8'h00, 8'h11);
      wr_start(8'h00, 8'hAA);
      repeat (3) @(negedge clk_i);
      chk(core_stall_o, 0);
      sfr(3'h4, 8'h01);
      chk(control_o[0], 0);
      wait_flag(1);
      setup(8'h00, 8'h80, 8'h00, 8'h22);
      wr_start(8'h00, 8'hAA);
      wait_flag(1);
      setup(8'h00, 8'hFF, 8'h00, 8'h5A);
      wr_start(8'h00, 8'hAA);
      wait_flag(1);
      rd(8'h00, 8'h00, 8'h00, 16'h0011);
      rd(8'h00, 8'h00, 8'h80, 16'h0022);
      rd(8'h00, 8'h00, 8'hFF, 16'h005A);
      setup(8'h00, 8'h00, 8'h00, 8'h99);
      wr_start(8'h00, 8'h55);
      wait_flag(0);
      rd(8'h00, 8'h00, 8'h00, 16'h0011);
      irq_enable_i = 1'b1;
      setup(8'h1F, 8'hFF, 8'h3A, 8'hBC);
      chk({addr_high_o, addr_low_o}, 16'h1FFF);
      wr_start(8'h80, 8'hAA);
      repeat (3) @(negedge clk_i);
      chk(core_stall_o, 1);
      irq_event_i = 1'b1;
      @(negedge clk_i);
      irq_event_i = 1'b0;
      chk(vec_cnt, 0);
      wait_flag(1);
      repeat (3) @(negedge clk_i);
      chk(vec_cnt, 1);
      rd(8'h80, 8'h1F, 8'hFF, 16'h3ABC);
      setup(8'h20, 8'h00, 8'h00, 8'h55);
      wr_start(8'h80, 8'hAA);
      wait_flag(0);
      rd(8'h80, 8'h00, 8'h00, 16'h0000);
      fetch_word_i = 14'h0001;
      fetch_valid_i = 1'b1;
      @(negedge clk_i);
      fetch_word_i = 14'h3ABC;
      @(negedge clk_i);
      fetch_valid_i = 1'b0;
      chk({exec_valid_o, exec_word_o}, 16'h4000);
      @(negedge clk_i);
      chk({exec_valid_o, exec_word_o}, 16'h7ABC);
      finish_test;
   end
endmodule // nv_self_access_tb
